// ===== usm_spi_master.sv
// USART in SPI master mode: baud generator, shared sequencer, data buffers.
// Assumes control ports come from same-clock register logic and miso_i from a pin.
`timescale 1ns/10ps
module usm_spi_master
  import usm_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  input  wire usm_cfg_s          cfg_i,
  input  wire logic [DATA_W-1:0] serial_data_register_i,
  input  wire logic              data_write_i,
  output logic                   data_write_ready_o,
  output logic [DATA_W-1:0]      rx_data_o,
  output logic                   rx_valid_o,
  input  wire logic              rx_read_i,
  output logic                   rx_overrun_o,
  output logic                   tx_complete_o,
  output logic                   rx_complete_o,
  output logic                   busy_o,
  output logic                   master_mode_o,
  output logic                   transfer_clock_pin_o,
  output logic                   transfer_clock_pin_oe_o,
  output logic                   mosi_o,
  output logic                   mosi_oe_o,
  input  wire logic              miso_i
);

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and pin synchroniser.

  usm_core_s         c_r;
  usm_core_s         c_nxt;
  logic              miso_meta_r;
  logic              miso_sync_r;
  logic              spi_on;
  logic              tick;
  logic [DATA_W-1:0] q_data;
  logic              q_valid;
  logic              q_pop;

  // Master mode needs both mode bits set; otherwise parity and recovery paths
  // are not part of this block at all, so nothing else is switched.
  function automatic logic is_master(input logic [1:0] m);
    is_master = (m == MODE_SPI_MASTER); // [R1] [R3]
  endfunction : is_master

  // Frame order: pick the outgoing bit from one end of the shifter.
  function automatic logic out_bit(input logic [DATA_W-1:0] d, input logic lsb);
    out_bit = lsb ? d[0] : d[DATA_W-1]; // [R17] [R18]
  endfunction : out_bit

  assign spi_on        = is_master(cfg_i.mode_select_field) & cfg_i.tx_enable; // [R20]
  assign master_mode_o = is_master(cfg_i.mode_select_field);

  // Two flops before the sequencer looks at incoming data.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      miso_meta_r <= 1'b0;
      miso_sync_r <= 1'b0;
    end
    else
    begin
      miso_meta_r <= miso_i;
      miso_sync_r <= miso_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit buffer: writes queue here while the shifter is busy.

  usm_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .in_data_i   (serial_data_register_i),
    .in_valid_i  (data_write_i & spi_on),
    .in_ready_o  (data_write_ready_o),
    .out_data_o  (q_data),
    .out_valid_o (q_valid),
    .out_ready_i (q_pop)
  ); // [R16] [R19]

  ////////////////////////////////////////////////////////////////////////////
  // Shared sequencer: one machine shifts both directions.

  // Half-period tick when the counter reaches zero, giving fosc/(2(div+1)).
  assign tick = (c_r.div_cnt == DIV_RESET); // [R10] [R11]
  assign q_pop = (c_r.state == USM_IDLE) & spi_on & q_valid;

  always_comb
  begin
    c_nxt         = c_r;
    c_nxt.tx_done = 1'b0;
    c_nxt.rx_done = 1'b0;
    // Divisor counter only runs during a transfer so the first edge is a full
    // half period after the load.
    if (c_r.state != USM_IDLE)
    begin
      c_nxt.div_cnt = tick ? cfg_i.baud_divisor : DIV_W'(c_r.div_cnt - 1'b1); // [R21]
    end
    if (rx_read_i)
    begin
      c_nxt.rx_full = 1'b0;
    end
    case (c_r.state)
      USM_IDLE:
      begin
        c_nxt.sck     = cfg_i.cpol; // [R22]
        c_nxt.div_cnt = cfg_i.baud_divisor;
        if (q_pop)
        begin
          c_nxt.tx_shift = q_data;
          c_nxt.bit_cnt  = BIT_FIRST;
          c_nxt.state    = USM_LEAD; // [R2] [R4]
          // Phase zero puts the first bit out before the leading edge.
          if (!cfg_i.cpha)
          begin
            c_nxt.mosi = out_bit(q_data, cfg_i.bit_order_select); // [R12]
          end
        end
      end
      USM_LEAD:
      begin
        if (tick)
        begin
          c_nxt.sck   = ~c_r.sck; // [R7] [R21]
          c_nxt.state = USM_TRAIL;
          if (cfg_i.cpha)
          begin
            c_nxt.mosi = out_bit(c_r.tx_shift, cfg_i.bit_order_select); // [R13]
          end
          else
          begin
            c_nxt.rx_shift = cfg_i.bit_order_select ?
                             {miso_sync_r, c_r.rx_shift[DATA_W-1:1]} :
                             {c_r.rx_shift[DATA_W-2:0], miso_sync_r}; // [R12] [R15]
          end
        end
      end
      USM_TRAIL:
      begin
        if (tick)
        begin
          c_nxt.sck = ~c_r.sck;
          // Shift out the bit just sent; capture on trailing edge for phase one.
          c_nxt.tx_shift = cfg_i.bit_order_select ? (c_r.tx_shift >> 1) :
                           (c_r.tx_shift << 1);
          if (cfg_i.cpha)
          begin
            c_nxt.rx_shift = cfg_i.bit_order_select ?
                             {miso_sync_r, c_r.rx_shift[DATA_W-1:1]} :
                             {c_r.rx_shift[DATA_W-2:0], miso_sync_r}; // [R13] [R15]
          end
          else
          begin
            c_nxt.mosi = cfg_i.bit_order_select ? c_r.tx_shift[1] :
                         c_r.tx_shift[DATA_W-2]; // [R13] [R17]
          end
          c_nxt.bit_cnt = BITCNT_W'(c_r.bit_cnt + 1'b1);
          c_nxt.state   = USM_LEAD;
          if (c_r.bit_cnt == BIT_LAST)
          begin
            c_nxt.state   = USM_IDLE;
            c_nxt.tx_done = 1'b1;
            // Receive only lands in the buffer when the receiver is on.
            if (cfg_i.rx_enable)
            begin
              c_nxt.rx_buf     = c_nxt.rx_shift; // [R16] [R20]
              c_nxt.rx_overrun = c_r.rx_full & ~rx_read_i;
              c_nxt.rx_full    = 1'b1; // Set wins over a same-cycle read.
              c_nxt.rx_done    = 1'b1;
            end
          end
        end
      end
      default:
      begin
        c_nxt.state = USM_IDLE;
      end
    endcase
    // Leaving master mode aborts any frame and parks the clock.
    if (!spi_on)
    begin
      c_nxt.state = USM_IDLE;
      c_nxt.sck   = cfg_i.cpol; // [R22]
    end
  end

  // State register.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      c_r <= '{state: USM_IDLE, div_cnt: DIV_RESET, bit_cnt: BIT_FIRST,
               tx_shift: DATA_RESET, rx_shift: DATA_RESET, rx_buf: DATA_RESET,
               default: 1'b0};
    end
    else
    begin
      c_r <= c_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs. Clock pin override follows the direction bit as in normal mode; data pin enable follows spi_on.

  assign transfer_clock_pin_o    = c_r.sck;
  assign transfer_clock_pin_oe_o = cfg_i.clock_pin_direction_bit; // [R5] [R8] [R9]
  assign mosi_o                  = c_r.mosi;
  assign mosi_oe_o               = spi_on; // [R5]
  assign rx_data_o               = c_r.rx_buf;
  assign rx_valid_o              = c_r.rx_full;
  assign rx_overrun_o            = c_r.rx_overrun;
  assign tx_complete_o           = c_r.tx_done;
  assign rx_complete_o           = c_r.rx_done;
  assign busy_o                  = (c_r.state != USM_IDLE) | q_valid; // [R6] [R14]

endmodule : usm_spi_master

// ===== usm_pkg.sv
// Constants and carrier types of the USART SPI master block.
// Assumes a single 10 MHz system clock and a synchronous active-low reset.
// Operation
// R1 - Master mode only when mode field equals 11
// R2 - SPI logic owns shifters, buffers, baud generator
// R3 - Parity and async recovery disabled in master mode
// R4 - One shared sequencer drives both directions
// R5 - Pin override and events same in modes
// R6 - Same registers, some control bits change meaning
// R7 - Internal clocking only, always drives clock
// R8 - Software sets clock pin direction to output
// R9 - Set clock direction before enabling transmitter
// R10 - Clock rate is system over 2(divisor+1)
// R11 - Divisor is 12 bits from high/low parts
// R12 - Polarity and phase select modes 0 to 3
// R13 - Drive on one edge, sample on other
// R14 - Software keeps polarity/phase fixed during transfer
// R15 - Full duplex, one receive bit per transmit bit
// R16 - Transmit and receive paths double buffered
// R17 - Bit order selectable, LSB or MSB first
// R18 - One bit-order control for both directions
// R19 - Data register write starts every transfer
// R20 - Transmitter enable required, receiver enable optional
// R21 - Divisor counter reloads, clock toggles only when active
// R22 - Idle clock rests at polarity level
package usm_pkg;

  localparam int unsigned DATA_W     = 8;
  localparam int unsigned DIV_W      = 12;
  localparam int unsigned DIVH_W     = 4;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned BITCNT_W   = 3;
  localparam logic [1:0]  MODE_SPI_MASTER = 2'h3;
  localparam logic [DIV_W-1:0]    DIV_RESET  = 12'h000;
  localparam logic [BITCNT_W-1:0] BIT_LAST   = 3'h7;
  localparam logic [BITCNT_W-1:0] BIT_FIRST  = 3'h0;
  localparam logic [DATA_W-1:0]   DATA_RESET = 8'h00;
  localparam int unsigned CLK_HZ = 10_000_000;

  // Sequencer states.
  typedef enum logic [1:0]
  {
    USM_IDLE  = 2'b00,
    USM_LEAD  = 2'b01,
    USM_TRAIL = 2'b10
  } usm_state_e;

  // Configuration carried from the control ports.
  typedef struct packed
  {
    logic [1:0]       mode_select_field;
    logic             cpol;
    logic             cpha;
    logic             bit_order_select;
    logic             tx_enable;
    logic             rx_enable;
    logic             clock_pin_direction_bit;
    logic [DIV_W-1:0] baud_divisor;
  } usm_cfg_s;

  // Sequencer state.
  typedef struct packed
  {
    usm_state_e          state;
    logic [DIV_W-1:0]    div_cnt;
    logic [BITCNT_W-1:0] bit_cnt;
    logic [DATA_W-1:0]   tx_shift;
    logic [DATA_W-1:0]   rx_shift;
    logic [DATA_W-1:0]   rx_buf;
    logic                rx_full;
    logic                rx_overrun;
    logic                sck;
    logic                mosi;
    logic                tx_done;
    logic                rx_done;
  } usm_core_s;

endpackage : usm_pkg

// ===== usm_fifo.sv
// Transmit queue of the USART SPI master block.
// Assumes both sides run on the same system clock.
`timescale 1ns/10ps
module usm_fifo
  import usm_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
)
(
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);

  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed
  {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
  } usm_fifo_s;

  usm_fifo_s            q_r;
  usm_fifo_s            q_nxt;
  logic [WIDTH-1:0]     mem_r [DEPTH];
  logic                 push;
  logic                 pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready_o  = (q_r.count != DEPTH[AW:0]);
  assign out_valid_o = (q_r.count != '0);
  assign out_data_o  = mem_r[q_r.rd_ptr];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Pointer and count update.
  always_comb
  begin
    q_nxt = q_r;
    if (push)
    begin
      q_nxt.wr_ptr = AW'(q_r.wr_ptr + 1'b1);
    end
    if (pop)
    begin
      q_nxt.rd_ptr = AW'(q_r.rd_ptr + 1'b1);
    end
    q_nxt.count = (AW+1)'(q_r.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
  end

  // Storage has no reset; only pointers and count need a defined value.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      q_r <= '0;
    end
    else
    begin
      q_r <= q_nxt;
    end
    if (push)
    begin
      mem_r[q_r.wr_ptr] <= in_data_i;
    end
  end

endmodule : usm_fifo

// ===== usm_chk.sv
// Port assertions for the serial master block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module usm_chk
  import usm_pkg::*;
(
  input wire logic     clk_i,
  input wire logic     resetn_i,
  input wire usm_cfg_s cfg_i,
  input wire logic     data_write_ready_o,
  input wire logic     tx_complete_o,
  input wire logic     rx_complete_o,
  input wire logic     busy_o,
  input wire logic     master_mode_o,
  input wire logic     transfer_clock_pin_o,
  input wire logic     transfer_clock_pin_oe_o,
  input wire logic     mosi_oe_o
);
  logic [12:0] half_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Cycles since the last edge in a frame; zero skips the first edge.
  always_ff @(posedge clk_i)
    if (!resetn_i || !busy_o || tx_complete_o) half_r <= '0;
    else if ($changed(transfer_clock_pin_o)) half_r <= 13'h0001;
    else if (half_r != '0) half_r <= half_r + 13'h0001;
////////////////////////////////////////
  // Each property ties an output to its cause.
  mode_dec_a: assert property (master_mode_o == (cfg_i.mode_select_field == 2'h3))
    else $error("mode flag wrong");
  clk_oe_a: assert property (transfer_clock_pin_oe_o == cfg_i.clock_pin_direction_bit)
    else $error("clock enable wrong");
  data_oe_a: assert property (mosi_oe_o == (master_mode_o && cfg_i.tx_enable))
    else $error("data enable wrong");
  half_per_a: assert property ($changed(transfer_clock_pin_o) && half_r != '0
    |-> half_r == {1'b0, cfg_i.baud_divisor} + 13'h0001) else $error("half period");
  idle_lvl_a: assert property ((master_mode_o && !busy_o && $stable(cfg_i.cpol))[*3]
    |-> transfer_clock_pin_o == cfg_i.cpol) else $error("idle level");
  only_act_a: assert property ($changed(transfer_clock_pin_o) && $past(resetn_i)
    && $past(resetn_i, 2)
    && $past(cfg_i.cpol, 2) == cfg_i.cpol |-> busy_o || $past(busy_o)) else $error("stray");
  tx_gap_a: assert property (tx_complete_o |=> !tx_complete_o [*8])
    else $error("frames too close");
  rx_en_a: assert property (rx_complete_o |-> tx_complete_o && cfg_i.rx_enable)
    else $error("receive pulse wrong");
  idle_rdy_a: assert property (!busy_o |-> data_write_ready_o)
    else $error("idle not ready");
  cover property (tx_complete_o && cfg_i.bit_order_select);
  cover property (!data_write_ready_o);
  cover property (rx_complete_o && cfg_i.cpol && cfg_i.cpha);
endmodule : usm_chk

bind usm_spi_master usm_chk u_chk (.clk_i, .resetn_i, .cfg_i, .data_write_ready_o,
  .tx_complete_o, .rx_complete_o, .busy_o, .master_mode_o, .transfer_clock_pin_o,
  .transfer_clock_pin_oe_o, .mosi_oe_o);

// ===== usm_slave_model.sv
// Behavioural slave on the three-wire link.
// Assumes load_i rises once per frame with tx_i already settled.
`timescale 1ns/10ps
module usm_slave_model
(
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       cpol_i,
  input  wire logic       cpha_i,
  input  wire logic       lsb_i,
  input  wire logic       load_i,
  input  wire logic [7:0] tx_i,
  output logic            miso_o = 1'b0,
  output logic [7:0]      rx_o
);
  int n = 8;
  int k = 8;
  // After the last bit the line toggles, so a stale bit never passes.
  task put;
    if (k < 8) miso_o = lsb_i ? tx_i[k] : tx_i[7-k];
    else miso_o = ~miso_o;
    k++;
  endtask : put
////////////////////////////////////////
  // With phase zero the first bit must stand before the first edge.
  always @(posedge load_i)
  begin
    n = 0;
    k = 0;
    if (!cpha_i) put;
  end
  // Edges outside a frame are ignored, so idle level moves are harmless.
  always @(sck_i)
    if (n < 8)
    begin
      if (sck_i == !(cpol_i ^ cpha_i))
      begin
        rx_o = lsb_i ? {mosi_i, rx_o[7:1]} : {rx_o[6:0], mosi_i};
        n++;
        if (n == 8) put;
      end
      else put;
    end
endmodule : usm_slave_model

// ===== usm_tb.sv
// Self-checking bench of the serial master against a slave model.
// Assumes the package constants and a 10 MHz system clock.
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module testbench
  import usm_pkg::*;
;
  logic        clk_i = 1'b0, resetn_i = 1'b0, data_write_i = 1'b0, rx_read_i = 1'b0;
  logic        load = 1'b0, miso_i, data_write_ready_o, rx_valid_o, rx_overrun_o;
  logic        tx_complete_o, rx_complete_o, busy_o, master_mode_o, transfer_clock_pin_o;
  logic        transfer_clock_pin_oe_o, mosi_o, mosi_oe_o;
  usm_cfg_s    cfg_i = '0;
  logic [7:0]  serial_data_register_i = 8'h00, rx_data_o, sbyte, srx;
  logic [15:0] expq[$], e;
  int          fail_count = 0, n_compared = 0, seed = 32, acc;
  always #50 clk_i = ~clk_i;
  usm_spi_master dut (.clk_i, .resetn_i, .cfg_i, .serial_data_register_i, .data_write_i,
    .data_write_ready_o, .rx_data_o, .rx_valid_o, .rx_read_i, .rx_overrun_o, .tx_complete_o,
    .rx_complete_o, .busy_o, .master_mode_o, .transfer_clock_pin_o, .transfer_clock_pin_oe_o,
    .mosi_o, .mosi_oe_o, .miso_i);
  usm_slave_model slv (.sck_i(transfer_clock_pin_o), .mosi_i(mosi_o), .cpol_i(cfg_i.cpol),
    .cpha_i(cfg_i.cpha), .lsb_i(cfg_i.bit_order_select), .load_i(load), .tx_i(sbyte),
    .miso_o(miso_i), .rx_o(srx));
////////////////////////////////////////
  task tick;
    @(posedge clk_i);
    #1;
  endtask : tick
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // Runs the given number of clock cycles and counts the frames that complete in them.
  task count_frames(input int cycles);
    acc = 0;
    repeat (cycles)
    begin
      tick;
      if (tx_complete_o === 1'b1) acc++;
    end
  endtask : count_frames
  // One full-duplex frame; polarity and phase change only while idle.
  task frame(input logic [1:0] m, input logic lsb);
    sbyte = $random(seed);
    cfg_i.cpol = m[1];
    cfg_i.cpha = m[0];
    cfg_i.bit_order_select = lsb;
    cfg_i.baud_divisor = 12'h002 + 12'($random(seed) & 3);
    repeat (3) tick;
    load = 1'b1;
    data_write_i = 1'b1;
    serial_data_register_i = $random(seed);
    expq.push_back({sbyte, serial_data_register_i});
    tick;
    load = 1'b0;
    data_write_i = 1'b0;
    acc = 0;
    while (tx_complete_o !== 1'b1 && acc < 2000)
    begin
      tick;
      acc++;
    end
    `CHK(rx_valid_o, 1'b1)
    rx_read_i = 1'b1;
    tick;
    rx_read_i = 1'b0;
    `CHK(rx_valid_o, 1'b0)
    `CHK(rx_overrun_o, 1'b0)
  endtask : frame
  // Received bytes are checked in both directions when the pulse shows.
  always @(negedge clk_i)
    if (rx_complete_o === 1'b1 && expq.size() > 0)
    begin
      e = expq.pop_front();
      `CHK(rx_data_o, e[15:8])
      `CHK(srx, e[7:0])
    end
  initial
  begin
    #1_000_000;
    fail_count++;
    summarize;
  end
  initial
  begin
    cfg_i.clock_pin_direction_bit = 1'b1;
    repeat (3) tick;
    resetn_i = 1'b1;
    cfg_i.mode_select_field = MODE_SPI_MASTER;
    cfg_i.tx_enable = 1'b1;
    cfg_i.rx_enable = 1'b1;
    for (int i = 0; i < 8; i++)
      frame(i[1:0], i[2]);
    // Fill the queue at the fastest rate; one byte goes straight to the shifter.
    cfg_i.rx_enable = 1'b0;
    cfg_i.baud_divisor = DIV_RESET;
    tick;
    acc = 0;
    data_write_i = 1'b1;
    repeat (12)
    begin
      serial_data_register_i = $random(seed);
      if (data_write_ready_o === 1'b1) acc++;
      tick;
    end
    data_write_i = 1'b0;
    `CHK(acc, 9)
    count_frames(400);
    `CHK(acc, 9)
    // A reset after the queue drains must leave the block idle with the clock parked.
    resetn_i = 1'b0;
    tick;
    resetn_i = 1'b1;
    tick;
    `CHK(busy_o, 1'b0)
    `CHK(transfer_clock_pin_o, cfg_i.cpol)
    // Writes in other modes or with the transmitter off start nothing.
    for (int c = 0; c < 4; c++)
    begin
      cfg_i.mode_select_field = (c < 3) ? c[1:0] : MODE_SPI_MASTER;
      cfg_i.tx_enable = (c < 3);
      tick;
      data_write_i = 1'b1;
      tick;
      data_write_i = 1'b0;
      count_frames(40);
      `CHK(acc, 0)
    end
    `CHK(expq.size(), 0)
    summarize;
  end
endmodule : testbench
